// ===== data_memory_bank_indirect_addressing_tb_top.sv
// Self-checking bench for the data memory bank with a reference model.
`timescale 1ns/1ps

module data_memory_bank_indirect_addressing_tb_top;
    // ==========================================================================
    // Signals and instances
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic wdt_pd_reset_i = 1'b0;
    dmb_pkg::dmb_req_s req;
    logic acc_we, pc_step, pc_load, bank_bit, dummy, nvm_sel;
    logic [7:0] acc_wdata, rdata, acc, ptr0, ptr1, a, d;
    logic [10:0] pc_load_val, pc;
    int n_fail = 0;
    int comparisons = 0;
    int mdat [2][256];

    dmb_core_model u_core (.clk_sys_i(clk_sys_i), .req_o(req), .acc_we_o(acc_we), .acc_wdata_o(acc_wdata),
        .pc_step_o(pc_step), .pc_load_o(pc_load), .pc_load_val_o(pc_load_val));
    dmb_core u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .wdt_pd_reset_i(wdt_pd_reset_i), .req_i(req),
        .acc_we_i(acc_we), .acc_wdata_i(acc_wdata), .pc_step_i(pc_step), .pc_load_val_i(pc_load_val),
        .pc_load_i(pc_load), .rdata_o(rdata), .acc_o(acc), .ptr0_o(ptr0), .ptr1_o(ptr1),
        .bank_select_bit_o(bank_bit), .pc_o(pc), .dummy_cycle_o(dummy), .nvm_ctrl_sel_o(nvm_sel));

    // Clock of 4 ns period.
    initial begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    // ==========================================================================
    // Reference model and helpers
    task automatic chk(input string n, input int e, input logic [10:0] g);
        comparisons++;
        if (g !== e[10:0]) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", n, e[10:0], g);
        end
    endtask : chk

    // Maps an address to bank and location; a negative location marks a port hitting a port.
    task automatic resolve(input int ad, output int b, output int ea);
        b = 0;
        ea = (ad == 0) ? mdat[0][1] : ad;
        if (ad == 2) begin
            ea = mdat[0][3];
            b = mdat[0][4];
        end
        if (ea < 'h40) b = 0;
        if ((ad == 0 || ad == 2) && (ea == 0 || ea == 2)) ea = -1;
    endtask : resolve

    // Writes through the core and mirrors the effect in the model.
    task automatic wr(input int ad, input int dv);
        int b;
        int ea;
        resolve(ad, b, ea);
        u_core.access(1'b0, 1'b1, ad[7:0], dv[7:0]);
        #1;
        if (ea >= 0) mdat[b][ea] = (ea == 4) ? (dv & 1) : (dv & 'hff);
    endtask : wr

    // Reads through the core and compares with the model.
    task automatic rd(input int ad);
        int b;
        int ea;
        resolve(ad, b, ea);
        u_core.access(1'b1, 1'b0, ad[7:0], 8'h00);
        #1;
        chk("rdata", (ea < 0) ? 0 : mdat[b][ea], {3'h0, rdata});
    endtask : rd

    // One-edge reset, optionally flagged as a watchdog reset in power-down.
    task automatic do_reset(input logic w);
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        wdt_pd_reset_i <= w;
        @(posedge clk_sys_i);
        rst_i <= 1'b0;
        wdt_pd_reset_i <= 1'b0;
        #1;
        for (int k = 1; k < 7; k++) begin
            if (k != 4 || !w) mdat[0][k] = 0;
        end
        chk("bank", mdat[0][4], {10'h0, bank_bit});
        chk("ptr0", 0, {3'h0, ptr0});
        chk("pc", 0, pc);
    endtask : do_reset

    task automatic final_report;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    // ==========================================================================
    // Tests
    initial begin
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        #1;
        chk("acc", 0, {3'h0, acc});
        chk("bank", 0, {10'h0, bank_bit});
        $display("test reset_values done");
        void'($urandom(44931));
        for (int i = 0; i < 8; i++) begin
            a = 8'h41 + 8'($urandom_range(0, 94));
            d = 8'($urandom);
            wr(4, i * 3);
            rd(4);
            chk("bank", i % 2, {10'h0, bank_bit});
            wr(3, a);
            chk("ptr1", a, {3'h0, ptr1});
            wr(2, d);
            wr(1, a);
            wr(0, ~d);
            rd(2);
            rd(a);
            rd(0);
            wr(3, i % 2 * 2);
            wr(2, d);
            rd(2);
            rd(3);
        end
        $display("test indirect_banks done");
        wr(4, 1);
        wr(3, 'h40);
        for (int k = 0; k < 2; k++) begin
            fork
                u_core.access(1'b1, 1'b0, k ? 8'h40 : 8'h02, 8'h00);
                begin
                    @(posedge clk_sys_i);
                    #1;
                    chk("nvm_sel", k == 0, {10'h0, nvm_sel});
                end
            join
        end
        u_core.strobe(1'b1, 1'b0, 1'b0, {3'h0, d});
        mdat[0][5] = d;
        rd(5);
        chk("acc", d, {3'h0, acc});
        u_core.strobe(1'b0, 1'b1, 1'b0, 11'h5a3);
        u_core.access(1'b0, 1'b1, 8'h06, d);
        #1;
        chk("pc", {3'h5, d}, pc);
        chk("dummy", 1, {10'h0, dummy});
        u_core.strobe(1'b0, 1'b0, 1'b1, 11'h000);
        #1;
        chk("pc", {3'h5, d} + 1, pc);
        $display("test nvm_acc_pcl done");
        do_reset(1'b1);
        do_reset(1'b0);
        $display("test resets done");
        final_report();
    end

    // Watchdog far beyond the few hundred cycles the tests need.
    initial begin
        #20000;
        n_fail++;
        final_report();
    end
endmodule : data_memory_bank_indirect_addressing_tb_top

// ===== dmb_addr_resolve.sv
// Address resolver that turns a core address into a bank and location.
`timescale 1ns/1ps

module dmb_addr_resolve (
    input wire logic [7:0] addr_i,
    input wire logic [7:0] ptr0_i,
    input wire logic [7:0] ptr1_i,
    input wire logic bank_i,
    output dmb_pkg::dmb_target_s tgt_o
);

    // ==========================================================================
    // Port detection
    wire is_port0 = (addr_i == dmb_pkg::ADDR_PORT0);
    wire is_port1 = (addr_i == dmb_pkg::ADDR_PORT1);
    wire [7:0] eff_addr = is_port0 ? ptr0_i : (is_port1 ? ptr1_i : addr_i);
    wire eff_bank = is_port1 ? bank_i : 1'b0;
    wire self_hit = (is_port0 || is_port1) &&
                    (eff_addr == dmb_pkg::ADDR_PORT0 || eff_addr == dmb_pkg::ADDR_PORT1);

    // Target assembly.
    assign tgt_o = '{bank: eff_bank, addr: eff_addr, null_hit: self_hit};

endmodule : dmb_addr_resolve

// ===== dmb_core.sv
// Data memory bank, pointers, accumulator and program counter low byte.
`timescale 1ns/1ps

module dmb_core (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic wdt_pd_reset_i,
    input wire dmb_pkg::dmb_req_s req_i,
    input wire logic acc_we_i,
    input wire logic [7:0] acc_wdata_i,
    input wire logic pc_step_i,
    input wire logic [10:0] pc_load_val_i,
    input wire logic pc_load_i,
    output logic [7:0] rdata_o,
    output logic [7:0] acc_o,
    output logic [7:0] ptr0_o,
    output logic [7:0] ptr1_o,
    output logic bank_select_bit_o,
    output logic [10:0] pc_o,
    output logic dummy_cycle_o,
    output logic nvm_ctrl_sel_o
);

    // ==========================================================================
    // Storage
    logic [7:0] ptr0_r;
    logic [7:0] ptr1_r;
    logic bank_r;
    logic [7:0] acc_r;
    logic [10:0] pc_r;
    logic dummy_r;
    logic [7:0] ram_b0 [dmb_pkg::RAM_DEPTH];
    logic [7:0] ram_b1 [dmb_pkg::RAM_DEPTH];
    logic [7:0] rdata_r;
    dmb_pkg::dmb_target_s tgt;

    dmb_addr_resolve u_resolve (
        .addr_i(req_i.addr),
        .ptr0_i(ptr0_r),
        .ptr1_i(ptr1_r),
        .bank_i(bank_r),
        .tgt_o(tgt)
    );

    // ==========================================================================
    // Decode
    wire acc_ok = !tgt.null_hit;
    wire sfr_hit = (tgt.addr < dmb_pkg::SFR_LIMIT);
    wire nvm_hit = (tgt.addr == dmb_pkg::ADDR_NVM_CTRL) && tgt.bank;
    wire gp_hit = !sfr_hit && (tgt.addr <= dmb_pkg::GP_TOP) && !tgt.bank;
    wire b1_hit = !sfr_hit && tgt.bank && !nvm_hit;
    wire wr_ok = req_i.wr && acc_ok;
    wire wr_ptr0 = wr_ok && (tgt.addr == dmb_pkg::ADDR_PTR0);
    wire wr_ptr1 = wr_ok && (tgt.addr == dmb_pkg::ADDR_PTR1);
    wire wr_bank = wr_ok && (tgt.addr == dmb_pkg::ADDR_BANK);
    wire wr_acc = wr_ok && (tgt.addr == dmb_pkg::ADDR_ACC);
    wire wr_pcl = wr_ok && (tgt.addr == dmb_pkg::ADDR_PCL) && !dummy_r;
    wire wr_gp = wr_ok && gp_hit;
    wire wr_b1 = wr_ok && b1_hit;

    // Read multiplexer; indirect ports pointing at themselves read zero.
    logic [7:0] rd_nxt;
    always_comb begin
        rd_nxt = dmb_pkg::ZERO_BYTE;
        if (!acc_ok) begin
            rd_nxt = dmb_pkg::ZERO_BYTE;
        end else begin
            case (tgt.addr)
                dmb_pkg::ADDR_PTR0: rd_nxt = ptr0_r;
                dmb_pkg::ADDR_PTR1: rd_nxt = ptr1_r;
                dmb_pkg::ADDR_BANK: rd_nxt = {7'h00, bank_r};
                dmb_pkg::ADDR_ACC: rd_nxt = acc_r;
                dmb_pkg::ADDR_PCL: rd_nxt = pc_r[7:0];
                default: begin
                    if (gp_hit) begin
                        rd_nxt = ram_b0[tgt.addr];
                    end else if (b1_hit) begin
                        rd_nxt = ram_b1[tgt.addr];
                    end
                end
            endcase
        end
    end

    // ==========================================================================
    // Pointer and bank registers
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ptr0_r <= dmb_pkg::RST_BYTE;
            ptr1_r <= dmb_pkg::RST_BYTE;
        end else begin
            if (wr_ptr0) ptr0_r <= req_i.wdata;
            if (wr_ptr1) ptr1_r <= req_i.wdata;
        end
    end

    // Bank bit survives only the watchdog reset taken in power-down.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i && !wdt_pd_reset_i) begin
            bank_r <= dmb_pkg::RST_BANK;
        end else if (!rst_i && wr_bank) begin
            bank_r <= req_i.wdata[dmb_pkg::BANK_BIT];
        end
    end

    // Accumulator: ALU results land here; a register write loads it too.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            acc_r <= dmb_pkg::RST_BYTE;
        end else if (acc_we_i) begin
            acc_r <= acc_wdata_i;
        end else if (wr_acc) begin
            acc_r <= req_i.wdata;
        end
    end

    // Program counter with in-page jump and one dummy cycle.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pc_r <= '0;
            dummy_r <= 1'b0;
        end else begin
            dummy_r <= wr_pcl;
            if (wr_pcl) begin
                pc_r <= {pc_r[10:8], req_i.wdata};
            end else if (pc_load_i) begin
                pc_r <= pc_load_val_i;
            end else if (pc_step_i && !dummy_r) begin
                pc_r <= pc_r + 11'h001;
            end
        end
    end

    // General purpose memory, no reset.
    always_ff @(posedge clk_sys_i) begin
        if (wr_gp) ram_b0[tgt.addr] <= req_i.wdata;
        if (wr_b1) ram_b1[tgt.addr] <= req_i.wdata;
    end

    // Registered read data.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rdata_r <= dmb_pkg::ZERO_BYTE;
        end else if (req_i.rd) begin
            rdata_r <= rd_nxt;
        end
    end

    // Outputs.
    assign rdata_o = rdata_r;
    assign acc_o = acc_r;
    assign ptr0_o = ptr0_r;
    assign ptr1_o = ptr1_r;
    assign bank_select_bit_o = bank_r;
    assign pc_o = pc_r;
    assign dummy_cycle_o = dummy_r;
    assign nvm_ctrl_sel_o = (req_i.rd || req_i.wr) && nvm_hit && acc_ok;

    // ==========================================================================
    // Assertions
    a_bank_reset: assert property (@(posedge clk_sys_i) rst_i && !wdt_pd_reset_i |=> !bank_r)
        else $error("bank not cleared by reset");
    a_bank_hold: assert property (@(posedge clk_sys_i) rst_i && wdt_pd_reset_i |=> $stable(bank_r))
        else $error("bank changed on power-down watchdog reset");
    a_self_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        req_i.rd && tgt.null_hit |=> rdata_o == 8'h00)
        else $error("indirect self access did not read zero");
    a_pcl_jump: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        wr_pcl |=> pc_o == {$past(pc_r[10:8]), $past(req_i.wdata)})
        else $error("pcl jump wrong target");
    a_dummy_cyc: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        wr_pcl |=> dummy_cycle_o ##1 !dummy_cycle_o)
        else $error("dummy cycle not one cycle");
    a_ptr_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        wr_ptr1 |=> ptr1_o == $past(req_i.wdata))
        else $error("pointer write lost");
    a_direct_bank: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        req_i.addr != dmb_pkg::ADDR_PORT1 |-> !tgt.bank)
        else $error("direct access left bank 0");
    a_acc_load: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        acc_we_i |=> acc_o == $past(acc_wdata_i))
        else $error("alu result not in accumulator");
    a_nvm_bank: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        nvm_ctrl_sel_o |-> bank_r)
        else $error("nvm control decoded outside bank 1");
    c_pcl_jump: cover property (@(posedge clk_sys_i) wr_pcl);
    c_ind_b1: cover property (@(posedge clk_sys_i) wr_b1);
    c_self_rd: cover property (@(posedge clk_sys_i) req_i.rd && tgt.null_hit);
    c_bank_keep: cover property (@(posedge clk_sys_i) rst_i && wdt_pd_reset_i);
    c_nvm_sel: cover property (@(posedge clk_sys_i) nvm_ctrl_sel_o);

    // ==========================================================================
    // Address resolution checks

    // Port 0 never leaves bank 0, whatever the bank bit says.
    a_port0_bank: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        req_i.addr == dmb_pkg::ADDR_PORT0 |-> !tgt.bank)
        else $error("port 0 access left bank 0");

    // Port 1 follows the bank bit.
    a_port1_bank: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        req_i.addr == dmb_pkg::ADDR_PORT1 |-> tgt.bank == bank_r)
        else $error("port 1 access ignored bank bit");

    // Port 0 is redirected to the location held in pointer 0.
    a_port0_addr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        req_i.addr == dmb_pkg::ADDR_PORT0 |-> tgt.addr == ptr0_r)
        else $error("port 0 not redirected by pointer 0");

    // Port 1 is redirected to the location held in pointer 1.
    a_port1_addr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        req_i.addr == dmb_pkg::ADDR_PORT1 |-> tgt.addr == ptr1_r)
        else $error("port 1 not redirected by pointer 1");

    // A direct access keeps its own address.
    a_direct_addr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        req_i.addr != dmb_pkg::ADDR_PORT0 && req_i.addr != dmb_pkg::ADDR_PORT1 |-> tgt.addr == req_i.addr)
        else $error("direct access address altered");

    // Pointer 0 aimed at a port marks the access as void.
    a_port0_null: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        req_i.addr == dmb_pkg::ADDR_PORT0 && (ptr0_r == dmb_pkg::ADDR_PORT0 || ptr0_r == dmb_pkg::ADDR_PORT1)
        |-> tgt.null_hit)
        else $error("port self access not flagged");

    // A void write enables no storage at all.
    a_self_nowr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        req_i.wr && tgt.null_hit |-> !wr_ok)
        else $error("indirect self write not dropped");

    // Special function addresses never reach either memory array.
    a_sfr_shared: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        sfr_hit |-> !gp_hit && !b1_hit)
        else $error("special address decoded as memory");

    // Bank 1 memory is written only through port 1.
    a_b1_port1: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        wr_b1 |-> req_i.addr == dmb_pkg::ADDR_PORT1)
        else $error("bank 1 written without port 1");

    // Bank 0 memory writes stay inside the general purpose range.
    a_gp_range: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        wr_gp |-> tgt.addr >= dmb_pkg::SFR_LIMIT && tgt.addr <= dmb_pkg::GP_TOP)
        else $error("bank 0 write outside general range");

    // The control register select only fires on its own address.
    a_nvm_addr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        nvm_ctrl_sel_o |-> tgt.addr == dmb_pkg::ADDR_NVM_CTRL)
        else $error("nvm control select on wrong address");

    // The control register location is not bank 1 memory.
    a_nvm_notram: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        nvm_hit |-> !b1_hit)
        else $error("nvm control address hit bank 1 memory");

    // ==========================================================================
    // Register checks

    // A bank write keeps only bit 0.
    a_bank_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        wr_bank |=> bank_r == $past(req_i.wdata[dmb_pkg::BANK_BIT]))
        else $error("bank bit write lost");

    // Bank reads show zero in the upper seven bits.
    a_bank_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        req_i.rd && acc_ok && tgt.addr == dmb_pkg::ADDR_BANK |=> rdata_o == {7'h00, $past(bank_r)})
        else $error("bank read not zero extended");

    // Pointer 0 stores what is written to it.
    a_ptr0_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        wr_ptr0 |=> ptr0_o == $past(req_i.wdata))
        else $error("pointer 0 write lost");

    // Pointer 0 reads back like a plain register.
    a_ptr0_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        req_i.rd && acc_ok && tgt.addr == dmb_pkg::ADDR_PTR0 |=> rdata_o == $past(ptr0_r))
        else $error("pointer 0 read wrong");

    // Pointer 1 reads back like a plain register.
    a_ptr1_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        req_i.rd && acc_ok && tgt.addr == dmb_pkg::ADDR_PTR1 |=> rdata_o == $past(ptr1_r))
        else $error("pointer 1 read wrong");

    // A register write to the accumulator lands when no ALU result competes.
    a_acc_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        wr_acc && !acc_we_i |=> acc_o == $past(req_i.wdata))
        else $error("accumulator register write lost");

    // The accumulator reads back its stored value.
    a_acc_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        req_i.rd && acc_ok && tgt.addr == dmb_pkg::ADDR_ACC |=> rdata_o == $past(acc_r))
        else $error("accumulator read wrong");

    // The low program counter byte reads back through the data space.
    a_pcl_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        req_i.rd && acc_ok && tgt.addr == dmb_pkg::ADDR_PCL |=> rdata_o == $past(pc_r[7:0]))
        else $error("pcl read wrong");

    // Read data stands until the next read.
    a_rdata_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !req_i.rd |=> $stable(rdata_o))
        else $error("read data changed without a read");

    // ==========================================================================
    // Program counter checks

    // The counter stands still during the dummy cycle unless fully loaded.
    a_pc_dummy: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        dummy_r && !pc_load_i |=> pc_o == $past(pc_r))
        else $error("pc moved during dummy cycle");

    // A plain step advances the counter by one.
    a_pc_step: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        pc_step_i && !dummy_r && !wr_pcl && !pc_load_i |=> pc_o == $past(pc_r) + 11'h001)
        else $error("pc step wrong");

    // A dummy cycle only follows a low byte write.
    a_dummy_src: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        dummy_cycle_o |-> $past(wr_pcl))
        else $error("dummy cycle without pcl write");

endmodule : dmb_core

// ===== dmb_core_model.sv
// Core stand-in that drives data memory, accumulator and program counter requests.
`timescale 1ns/1ps

module dmb_core_model (
    input wire logic clk_sys_i,
    output dmb_pkg::dmb_req_s req_o,
    output logic acc_we_o,
    output logic [7:0] acc_wdata_o,
    output logic pc_step_o,
    output logic pc_load_o,
    output logic [10:0] pc_load_val_o
);
    // Idle levels from time zero.
    initial begin
        req_o = '0;
        {acc_we_o, acc_wdata_o, pc_step_o, pc_load_o, pc_load_val_o} = '0;
    end

    // One access for one taking edge; afterwards address and data show their inverse, not stale values.
    task automatic access(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        req_o <= '{r, w, a, d};
        @(posedge clk_sys_i);
        req_o <= '{1'b0, 1'b0, ~a, ~d};
    endtask : access

    // One strobe of ALU write, program counter load or program counter step.
    task automatic strobe(input logic aw, input logic ld, input logic st, input logic [10:0] v);
        @(posedge clk_sys_i);
        {acc_we_o, pc_load_o, pc_step_o} <= {aw, ld, st};
        {acc_wdata_o, pc_load_val_o} <= {v[7:0], v};
        @(posedge clk_sys_i);
        {acc_we_o, pc_load_o, pc_step_o} <= 3'h0;
    endtask : strobe
endmodule : dmb_core_model

// ===== dmb_pkg.sv
// Constants, types and field layouts of the data memory bank and indirect addressing block.
//
// How it works
// - An access to either indirect data port is redirected to the location held in that port's memory pointer.
// - The first pointer pair reaches only bank 0, the second reaches the bank chosen by the bank selector.
// - An indirect access that lands on an indirect port address reads zero and writes nothing.
// - Both memory pointers are real 8-bit registers that read, write and modify like any other register.
// - Direct accesses always go to bank 0 whatever the bank selector holds.
// - Bit 0 of the bank selector chooses between bank 0 and bank 1.
// - Every reset returns the bank selection to bank 0, except a watchdog time-out reset in power-down.
// - Special function addresses decode to the same registers in every bank.
// - ALU results go to the accumulator and no direct memory-to-memory move exists.
// - Writing the program counter low byte jumps within the current page by replacing only the low 8 bits.
// - Such a jump inserts one dummy instruction cycle before execution resumes.
// - The non-volatile memory control register at 40H decodes only while bank 1 is selected.
// - Bank selector bits 7 to 1 read as zero and bit 0 resets to 0.
package dmb_pkg;

    // ==========================================================================
    // Addresses and widths
    localparam int DATA_W = 8;
    localparam int PC_W = 11;
    localparam logic [7:0] ADDR_PORT0 = 8'h00;
    localparam logic [7:0] ADDR_PTR0 = 8'h01;
    localparam logic [7:0] ADDR_PORT1 = 8'h02;
    localparam logic [7:0] ADDR_PTR1 = 8'h03;
    localparam logic [7:0] ADDR_BANK = 8'h04;
    localparam logic [7:0] ADDR_ACC = 8'h05;
    localparam logic [7:0] ADDR_PCL = 8'h06;
    localparam logic [7:0] ADDR_NVM_CTRL = 8'h40;
    localparam logic [7:0] SFR_LIMIT = 8'h40;
    localparam logic [7:0] GP_TOP = 8'h9F;
    localparam int RAM_DEPTH = 256;
    localparam int BANK_BIT = 0;

    // ==========================================================================
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic RST_BANK = 1'b0;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // Access request from the core.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dmb_req_s;

    // Resolved physical target of an access.
    typedef struct packed {
        logic bank;
        logic [7:0] addr;
        logic null_hit;
    } dmb_target_s;

endpackage : dmb_pkg
